// ===== src/input_sync.sv
module input_sync (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // asynchronous level
    input wire logic i_level,
    // filtered level
    output logic o_level
);
    import osc_timer_pkg::*;

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;

    // =========================================================
    // three-stage sampler; s1 feeds only s2
    // =========================================================
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_reg <= SYNC_RST;
            s2_reg <= SYNC_RST;
            s3_reg <= SYNC_RST;
        end else begin
            s1_reg <= i_level;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // =========================================================
    // accept a change only once stages two and three agree
    // =========================================================
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            level_reg <= SYNC_RST;
        end else if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
        end
    end

    assign o_level = level_reg;

endmodule : input_sync

// ===== src/osc_timer_pkg.sv
package osc_timer_pkg;

    // =========================================================
    // clocking
    // =========================================================
    localparam int unsigned MCLK_FREQ_KHZ = 200000;
    localparam int unsigned OSC_FREQ_KHZ = 5000;
    // master clock cycles per oscillator half period
    localparam int unsigned OSC_HALF_CYCLES = MCLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ);
    localparam int unsigned PHASE_W = 5;
    localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(OSC_HALF_CYCLES - 1);

    // =========================================================
    // divider
    // =========================================================
    localparam int unsigned DIV_CNT_W = 20;
    localparam int unsigned DIV_BITS_128 = 7;
    localparam int unsigned DIV_BITS_1024 = 10;
    localparam int unsigned DIV_BITS_1M = 20;

    typedef enum {
        DIV_128,
        DIV_1024,
        DIV_1M
    } div_sel_type;

    // =========================================================
    // reset values
    // =========================================================
    localparam logic [PHASE_W-1:0] PHASE_RST = 5'h00;
    localparam logic [DIV_CNT_W-1:0] DIV_CNT_RST = 20'h00000;
    localparam logic SYNC_RST = 1'b0;

    // =========================================================
    // carriers
    // =========================================================
    typedef struct packed {
        logic divider_reset;
        logic osc_disable;
    } fabric_in_type;

    typedef struct packed {
        logic osc_clk;
        logic divided_tick;
    } timer_out_type;

endpackage : osc_timer_pkg

// ===== src/osc_timer_unit.sv
module osc_timer_unit #(
    parameter osc_timer_pkg::div_sel_type DIV_SEL = osc_timer_pkg::DIV_128
) (
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST,
    // fabric controls
    input wire logic I_DIVIDER_RESET_IN,
    input wire logic I_OSC_DISABLE_IN,
    // routing outputs
    output logic O_OSC_CLK_OUT,
    output logic O_DIVIDED_TICK_OUT
);
    import osc_timer_pkg::*;

    fabric_in_type fabric_sync;
    timer_out_type timer_out;
    logic [PHASE_W-1:0] phase_reg;
    logic osc_reg;
    logic osc_rise;
    logic divider_reset_reg;
    logic [DIV_CNT_W-1:0] div_cnt_reg;
    logic [DIV_CNT_W-1:0] div_cnt_next;

    // =========================================================
    // ratio to divider width
    // =========================================================
    function automatic int unsigned div_bits(div_sel_type sel);
        int unsigned bits;
        bits = DIV_BITS_128;
        case (sel)
            DIV_128: bits = DIV_BITS_128;
            DIV_1024: bits = DIV_BITS_1024;
            DIV_1M: bits = DIV_BITS_1M;
            default: bits = DIV_BITS_128;
        endcase
        return bits;
    endfunction : div_bits

    localparam int unsigned TICK_BIT = div_bits(DIV_SEL) - 1;

    // =========================================================
    // fabric inputs arrive from outside this clock domain
    // =========================================================
    input_sync u_sync_reset (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_level(I_DIVIDER_RESET_IN),
        .o_level(fabric_sync.divider_reset)
    );

    input_sync u_sync_disable (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_level(I_OSC_DISABLE_IN),
        .o_level(fabric_sync.osc_disable)
    );

    // =========================================================
    // oscillator
    // =========================================================
    // disable parks the oscillator low so no stray edge leaks out on restart
    always_ff @(posedge I_MCLK) begin
        if (I_RST || fabric_sync.osc_disable) begin
            phase_reg <= PHASE_RST;
        end else if (phase_reg == PHASE_LAST) begin
            phase_reg <= PHASE_RST;
        end else begin
            phase_reg <= phase_reg + 5'h01;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST || fabric_sync.osc_disable) begin
            osc_reg <= 1'b0;
        end else if (phase_reg == PHASE_LAST) begin
            osc_reg <= ~osc_reg;
        end
    end

    // one master cycle ahead of the visible oscillator rising edge
    assign osc_rise = (phase_reg == PHASE_LAST) && !osc_reg && !fabric_sync.osc_disable;

    // =========================================================
    // reset register, sampled on oscillator rising edges only
    // =========================================================
    always_ff @(posedge I_MCLK) begin
        if (I_RST || fabric_sync.osc_disable) begin
            divider_reset_reg <= 1'b1;
        end else if (osc_rise) begin
            divider_reset_reg <= fabric_sync.divider_reset;
        end
    end

    // =========================================================
    // divider
    // =========================================================
    always_comb begin
        div_cnt_next = div_cnt_reg;
        if (osc_rise) begin
            if (divider_reset_reg) begin
                div_cnt_next = DIV_CNT_RST;
            end else begin
                div_cnt_next = div_cnt_reg + 20'h00001;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST || fabric_sync.osc_disable) begin
            div_cnt_reg <= DIV_CNT_RST;
        end else begin
            div_cnt_reg <= div_cnt_next;
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    assign timer_out.osc_clk = osc_reg;
    assign timer_out.divided_tick = div_cnt_reg[TICK_BIT];

    assign O_OSC_CLK_OUT = timer_out.osc_clk;
    assign O_DIVIDED_TICK_OUT = timer_out.divided_tick;

endmodule : osc_timer_unit

// ===== verif/fabric_logic_model.sv
// ==========
// fabric logic driving the timer controls
module fabric_logic_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_osc,
    input wire logic i_want_reset,
    input wire logic i_want_disable,
    output logic o_divider_reset,
    output logic o_osc_disable
);
    timeunit 1ns;
    timeprecision 100ps;
    logic osc_prev_reg;
    always_ff @(posedge i_clk) begin
        osc_prev_reg <= i_osc;
    end
    // reset moves only just after an osc rise, so the first tick is not shifted
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_divider_reset <= 1'b0;
        end else if (i_osc && !osc_prev_reg) begin
            o_divider_reset <= i_want_reset;
        end
    end
    // disable cannot wait for the osc, which it stops
    always_ff @(posedge i_clk) begin
        o_osc_disable <= i_want_disable && !i_rst;
    end
endmodule : fabric_logic_model

// ===== verif/osc_timer_checker.sv
// ==========
// port checks for the oscillator timer
module osc_timer_checker #(
    parameter osc_timer_pkg::div_sel_type DIV_SEL = osc_timer_pkg::DIV_128
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_DIVIDER_RESET_IN,
    input wire logic I_OSC_DISABLE_IN,
    input wire logic O_OSC_CLK_OUT,
    input wire logic O_DIVIDED_TICK_OUT
);
    import osc_timer_pkg::*;
    localparam int BITS = DIV_SEL == DIV_1M ? DIV_BITS_1M :
        DIV_SEL == DIV_1024 ? DIV_BITS_1024 : DIV_BITS_128;
    localparam int HALF = (2 * OSC_HALF_CYCLES) << (BITS - 1);
    logic tick_prev_reg;
    int run_reg;
    always_ff @(posedge I_MCLK) begin
        tick_prev_reg <= O_DIVIDED_TICK_OUT;
    end
    // cycles the tick has held its level, seen at the edge where it changes
    always_ff @(posedge I_MCLK) begin
        run_reg <= (I_RST || O_DIVIDED_TICK_OUT != tick_prev_reg) ? 1 : run_reg + 1;
    end
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RST || I_OSC_DISABLE_IN);
    osc_high_a: assert property ($rose(O_OSC_CLK_OUT) |->
        ##19 O_OSC_CLK_OUT ##1 !O_OSC_CLK_OUT) else $error("osc high phase wrong");
    osc_low_a: assert property ($fell(O_OSC_CLK_OUT) |->
        ##19 !O_OSC_CLK_OUT ##1 O_OSC_CLK_OUT) else $error("osc low phase wrong");
    tick_edge_a: assert property ($changed(O_DIVIDED_TICK_OUT) |->
        $rose(O_OSC_CLK_OUT)) else $error("tick moved off an osc rise");
    tick_high_a: assert property (disable iff (I_RST || I_OSC_DISABLE_IN ||
        I_DIVIDER_RESET_IN) $fell(O_DIVIDED_TICK_OUT) |-> run_reg == HALF)
        else $error("tick high length wrong");
    tick_low_a: assert property ($rose(O_DIVIDED_TICK_OUT) |->
        run_reg >= HALF) else $error("tick low too short");
    // sync latency, one osc period to latch the reset register, one more to clear the count
    div_reset_a: assert property (I_DIVIDER_RESET_IN &&
        $past(I_DIVIDER_RESET_IN, 100) |-> !O_DIVIDED_TICK_OUT) else $error("tick in reset");
    disable_hold_a: assert property (disable iff (I_RST) I_OSC_DISABLE_IN[*8] |->
        !O_OSC_CLK_OUT && !O_DIVIDED_TICK_OUT) else $error("outputs run while disabled");
endmodule : osc_timer_checker

bind osc_timer_unit osc_timer_checker #(.DIV_SEL(DIV_SEL)) osc_timer_checker_i (
    .I_MCLK(I_MCLK), .I_RST(I_RST), .I_DIVIDER_RESET_IN(I_DIVIDER_RESET_IN),
    .I_OSC_DISABLE_IN(I_OSC_DISABLE_IN), .O_OSC_CLK_OUT(O_OSC_CLK_OUT),
    .O_DIVIDED_TICK_OUT(O_DIVIDED_TICK_OUT));

// ===== verif/osc_timer_unit_tb_top.sv
`define CHECK_EQ(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
    miscompares++; $display("MISMATCH %s expected %0d seen %0d", what, exp, got); end end
// ==========
// oscillator timer bench
module osc_timer_unit_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, want_reset, want_disable, div_reset, osc_dis;
    logic [1:0] osc, tick;
    int compares, miscompares;
    osc_timer_unit osc_timer_unit_i (.I_MCLK(clk), .I_RST(rst), .I_DIVIDER_RESET_IN(div_reset),
        .I_OSC_DISABLE_IN(osc_dis), .O_OSC_CLK_OUT(osc[0]), .O_DIVIDED_TICK_OUT(tick[0]));
    osc_timer_unit #(.DIV_SEL(osc_timer_pkg::DIV_1024)) osc_timer_unit_wide_i (.I_MCLK(clk),
        .I_RST(rst), .I_DIVIDER_RESET_IN(div_reset), .I_OSC_DISABLE_IN(osc_dis),
        .O_OSC_CLK_OUT(osc[1]), .O_DIVIDED_TICK_OUT(tick[1]));
    fabric_logic_model fabric_logic_model_i (.i_clk(clk), .i_rst(rst), .i_osc(osc[0]),
        .i_want_reset(want_reset), .i_want_disable(want_disable),
        .o_divider_reset(div_reset), .o_osc_disable(osc_dis));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // counts osc rises until the tick reaches the level, the final rise included
    task automatic rises(input int idx, input logic lvl, output int n);
        logic prev;
        n = 0;
        prev = osc[0];
        for (int g = 0; tick[idx] !== lvl; g++) begin
            step(1);
            n += int'(osc[0] && !prev);
            prev = osc[0];
            if (g > 30000) begin
                miscompares++;
                print_verdict();
            end
        end
    endtask : rises
    task automatic ratio_check(input int idx, input int first, input int high);
        int n;
        rst = 1'b1;
        step(5);
        rst = 1'b0;
        step(1);
        `CHECK_EQ("tick after reset", 1'b0, tick[idx])
        rises(idx, 1'b1, n);
        `CHECK_EQ("rises to first tick", first, n)
        rises(idx, 1'b0, n);
        `CHECK_EQ("rises in tick high", high, n)
    endtask : ratio_check
    task automatic divider_reset_check;
        int n;
        rises(0, 1'b1, n);
        want_reset = 1'b1;
        step(200);
        `CHECK_EQ("tick held in reset", 1'b0, tick[0])
        for (int i = 0; i < 40 && osc[0]; i++) step(1);
        want_reset = 1'b0;
        rises(0, 1'b1, n);
        `CHECK_EQ("rises after reset", 66, n)
    endtask : divider_reset_check
    task automatic disable_check;
        int n;
        logic seen;
        rises(0, 1'b1, n);
        want_disable = 1'b1;
        step(10);
        seen = 1'b0;
        for (int i = 0; i < 100; i++) begin
            step(1);
            seen |= osc[0] | tick[0];
        end
        `CHECK_EQ("outputs while disabled", 1'b0, seen)
        want_disable = 1'b0;
        rises(0, 1'b1, n);
        `CHECK_EQ("rises after enable", 65, n)
    endtask : disable_check
    initial begin
        rst = 1'b1;
        want_reset = 1'b0;
        want_disable = 1'b0;
        compares = 0;
        miscompares = 0;
        ratio_check(0, 65, 64);
        ratio_check(1, 513, 512);
        divider_reset_check();
        disable_check();
        print_verdict();
    end
endmodule : osc_timer_unit_tb_top
